// ---- dv/mmc_mode_control_sva.sv ----
`timescale 1ns/1ns

module mmc_mode_control_sva (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       rxDescLenWriteReq,
  input wire logic       rxEopReq,
  input wire logic       rxFifoTrigger,
  input wire logic       datapathBusy,
  input wire logic       rxDescLenWriteEn,
  input wire logic       rxOwnerWrite,
  input wire logic       rxOwnerValue,
  input wire logic       pauseFrameReq,
  input wire logic       linkGig,
  input wire logic       linkFullDuplex,
  input wire logic       idleCommand,
  input wire logic       idleReached,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Counts quiet cycles under an idle command; saturates so it never wraps
  logic [3:0] quietCnt;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst || !idleCommand || datapathBusy) quietCnt <= 4'h0;
    else if (quietCnt != 4'hF) quietCnt <= quietCnt + 4'h1;
  end
  sequence eopSeen;
    rxEopReq;
  endsequence
  sequence triggerSeen;
    $past(rxFifoTrigger) && $past(linkFullDuplex);
  endsequence
  chk_len_write_gate: assert property (rxDescLenWriteEn |-> $past(rxDescLenWriteReq))
    else $error("descriptor length write without request");
  chk_owner_pulse: assert property (eopSeen |=> rxOwnerWrite)
    else $error("no ownership write after end of packet");
  chk_owner_hold: assert property ($changed(rxOwnerValue) |-> rxOwnerWrite)
    else $error("ownership value moved without end of packet");
  chk_pause_cause: assert property (pauseFrameReq |-> triggerSeen)
    else $error("pause frame without trigger in full duplex");
  chk_gig_full: assert property (linkGig |-> linkFullDuplex)
    else $error("gigabit link not full duplex");
  chk_idle_cmd: assert property (idleReached |-> idleCommand || $past(idleCommand))
    else $error("idle reached without command");
  chk_idle_early: assert property ($rose(idleReached) |-> quietCnt >= 4'h7)
    else $error("idle reached too early");
  chk_idle_late: assert property (quietCnt >= 4'hB |-> idleReached)
    else $error("idle not reached after quiet period");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
endmodule

bind mmc_mode_control mmc_mode_control_sva chk_u (.mclk, .rst, .rxDescLenWriteReq, .rxEopReq,
  .rxFifoTrigger, .datapathBusy, .rxDescLenWriteEn, .rxOwnerWrite, .rxOwnerValue, .pauseFrameReq,
  .linkGig, .linkFullDuplex, .idleCommand, .idleReached, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp);

// ---- dv/mmc_mode_control_tb.sv ----
`timescale 1ns/1ns
`include "mmc_defs.svh"

module mmc_mode_control_tb;
  logic        mclk = 1'h0, rst = 1'h1, clkEn = 1'h1, phyFull = 1'h0, phyGig = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rdv;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        inbandDuplexPin, inbandSpeedPin, inbandReceiveEnable, linkGig, linkFullDuplex;
  logic        rxDescLenWriteReq = 1'h0, rxEopReq = 1'h0, rxFifoTrigger = 1'h0;
  logic        datapathBusy = 1'h0;
  logic        rmiiFullDuplex, rmiiRate25m, rxDescLenWriteEn, rxOwnerWrite, rxOwnerValue;
  logic        pauseFrameReq, idleCommand, idleReached;
  int          errorCnt = 0, checks = 0, n;
  logic [31:0] cv [7] = '{32'h0004_0000, 32'h0004_0000, 32'h0004_0000, 32'h0000_0001,
                          32'h0000_0000, 32'h0000_0080, 32'h0002_0000};
  // Per case: PHY full, PHY gig, expected gig, expected full
  logic [3:0]  lv [7] = '{4'h9, 4'h0, 4'h7, 4'h5, 4'h4, 4'h3, 4'h3};

  always #20 mclk = ~mclk;

  mmc_phy_model phy_u (.full(phyFull), .thousand_meg_select(phyGig), .inbandDuplexPin, .inbandSpeedPin);
  mmc_mode_control dut_u (.mclk, .rst, .clkEn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .inbandDuplexPin, .inbandSpeedPin, .rxDescLenWriteReq,
    .rxEopReq, .rxFifoTrigger, .datapathBusy, .inbandReceiveEnable, .linkGig, .linkFullDuplex,
    .rmiiFullDuplex, .rmiiRate25m, .rxDescLenWriteEn, .rxOwnerWrite, .rxOwnerValue,
    .pauseFrameReq, .idleCommand, .idleReached);

  task automatic conclude;
    if (errorCnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      errorCnt++;
      $display("CHECK FAILED %0t got %h want %h", $time, s, e);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask

  // Ready and valid are sampled mid-cycle: they only move at rising edges
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int  k;
    logic ta, tw, tk;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    k = 0;
    tk = 1'h0;
    while (!tk && k < 40) begin
      @(negedge mclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tk = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge mclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      k++;
    end
    s_axi_bready <= 1'h0;
    if (!tk) begin
      errorCnt++;
      conclude();
    end
  endtask

  task automatic rd(input logic [11:0] a);
    int  k;
    logic ta, tk;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    k = 0;
    tk = 1'h0;
    while (!tk && k < 40) begin
      @(negedge mclk);
      ta = s_axi_arvalid & s_axi_arready;
      tk = s_axi_rvalid;
      rdv = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge mclk);
      if (ta) s_axi_arvalid <= 1'h0;
      k++;
    end
    s_axi_rready <= 1'h0;
    if (!tk) begin
      errorCnt++;
      conclude();
    end
  endtask

  initial begin
    cyc(4);
    rst <= 1'h0;
    cyc(1);
    rd(`MMC_CONTROL_ADDR);
    chk(rdv, `MMC_CONTROL_RESET);
    wr(`MMC_CONTROL_ADDR, 32'hFFFF_FFFF);
    rd(`MMC_CONTROL_ADDR);
    chk(rdv, `MMC_CONTROL_MASK);
    @(negedge mclk);
    chk({28'h0, inbandReceiveEnable, rmiiFullDuplex, rmiiRate25m, idleCommand}, 32'hF);
    cyc(1);
    rd(12'h00C);
    chk({30'h0, rsp}, {30'h0, `MMC_RESP_SLVERR});
    for (int i = 0; i < 7; i++) begin
      phyFull <= lv[i][3];
      phyGig <= lv[i][2];
      wr(`MMC_CONTROL_ADDR, cv[i]);
      cyc(6);
      rd(`MMC_STATUS_ADDR);
      chk(rdv & 32'h0000_0006, {29'h0, lv[i][0], lv[i][1], 1'h0});
      chk({30'h0, linkGig, linkFullDuplex}, {30'h0, lv[i][1:0]});
    end
    rxDescLenWriteReq <= 1'h1;
    wr(`MMC_CONTROL_ADDR, 32'h0000_4000);
    @(negedge mclk);
    chk({31'h0, rxDescLenWriteEn}, 32'h0);
    cyc(1);
    wr(`MMC_CONTROL_ADDR, 32'h0000_0000);
    @(negedge mclk);
    chk({31'h0, rxDescLenWriteEn}, 32'h1);
    cyc(1);
    rxDescLenWriteReq <= 1'h0;
    for (int v = 0; v < 2; v++) begin
      wr(`MMC_CONTROL_ADDR, v ? 32'h0000_3001 : 32'h0000_0001);
      cyc(4);
      rxEopReq <= 1'h1;
      rxFifoTrigger <= 1'h1;
      cyc(1);
      rxEopReq <= 1'h0;
      rxFifoTrigger <= 1'h0;
      @(negedge mclk);
      chk({30'h0, rxOwnerWrite, rxOwnerValue}, {30'h0, 1'h1, v[0]});
      chk({31'h0, pauseFrameReq}, {31'h0, v[0]});
      cyc(1);
    end
    wr(`MMC_CONTROL_ADDR, 32'h0000_0001);
    @(negedge mclk);
    chk({31'h0, rxOwnerValue}, 32'h1);
    cyc(1);
    // Software end of packet takes the current owner bit; trigger alone makes no pause
    wr(`MMC_EVENT_ADDR, 32'h0000_0003);
    @(negedge mclk);
    chk({29'h0, rxOwnerWrite, rxOwnerValue, pauseFrameReq}, 32'h4);
    chk({30'h0, rsp}, {30'h0, `MMC_RESP_OKAY});
    cyc(1);
    wr(12'h00C, 32'hFFFF_FFFF);
    chk({30'h0, rsp}, {30'h0, `MMC_RESP_SLVERR});
    cyc(1);
    datapathBusy <= 1'h1;
    wr(`MMC_CONTROL_ADDR, 32'h0000_0800);
    cyc(12);
    @(negedge mclk);
    chk({31'h0, idleReached}, 32'h0);
    cyc(1);
    datapathBusy <= 1'h0;
    n = 0;
    while (idleReached !== 1'h1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    chk(n, `MMC_IDLE_QUIET_CYC + 1);
    cyc(1);
    rd(`MMC_STATUS_ADDR);
    chk(rdv & 32'h0000_0001, 32'h1);
    wr(`MMC_CONTROL_ADDR, 32'h0000_0000);
    cyc(2);
    rd(`MMC_STATUS_ADDR);
    chk(rdv & 32'h0000_0001, 32'h0);
    chk({28'h0, inbandReceiveEnable, rmiiFullDuplex, rmiiRate25m, idleCommand}, 32'h0);
    conclude();
  end
endmodule

// ---- dv/mmc_phy_model.sv ----
`timescale 1ns/1ns

// PHY in-band status; a gigabit link is always reported full duplex
module mmc_phy_model (
  input  wire logic full,
  input  wire logic thousand_meg_select,
  output logic      inbandDuplexPin,
  output logic      inbandSpeedPin
);
  assign inbandDuplexPin = full | thousand_meg_select;
  assign inbandSpeedPin  = thousand_meg_select;
endmodule

// ---- verilog/mmc_defs.svh ----
`ifndef MMC_DEFS_SVH
`define MMC_DEFS_SVH

// Byte addresses on the register bus
`define MMC_CONTROL_ADDR      12'h0000
`define MMC_STATUS_ADDR       12'h0004
`define MMC_EVENT_ADDR        12'h0008

// Control register field positions
`define MMC_FULL_DUPLEX_BIT   0
`define MMC_GIG_BIT           7
`define MMC_IDLE_REQ_BIT      11
`define MMC_RXFIFO_PAUSE_BIT  12
`define MMC_OWNER_VAL_BIT     13
`define MMC_LEN_BLOCK_BIT     14
`define MMC_RMII_RATE_BIT     15
`define MMC_RMII_DUPLEX_BIT   16
`define MMC_GIG_FORCE_BIT     17
`define MMC_INBAND_SEL_BIT    18

// Writable bits of the control word; bits 6..1, 10..8 and 31..19 stay zero
`define MMC_CONTROL_MASK      32'h0007_F881
`define MMC_CONTROL_RESET     32'h0000_0000

// Status register field positions
`define MMC_ST_IDLE_BIT       0
`define MMC_ST_GIG_BIT        1
`define MMC_ST_FULL_BIT       2
`define MMC_ST_RMII_RATE_BIT  3

// Event register: write-one pulses
`define MMC_EV_EOP_BIT        0
`define MMC_EV_FIFO_TRIG_BIT  1

// Idle is reached once the datapath has been quiet this many cycles
`define MMC_IDLE_QUIET_CYC    4'h8

// AXI responses
`define MMC_RESP_OKAY         2'h0
`define MMC_RESP_SLVERR       2'h2

`endif

// ---- verilog/mmc_link_select.sv ----
`timescale 1ns/1ns
`include "mmc_defs.svh"

// Chooses link speed and duplex from in-band status or register bits
module mmc_link_select (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic clkEn,
  input  wire logic inbandSel,
  input  wire logic inbandDuplex,
  input  wire logic inbandSpeed,
  input  wire logic regDuplex,
  input  wire logic regGig,
  input  wire logic stopped_clock_speed_force,
  output logic      linkGig,
  output logic      linkFull
);

  typedef struct packed {
    logic thousand_meg_select;
    logic full;
  } mmc_sel_type;

  mmc_sel_type st;
  mmc_sel_type next_st;

  always_comb begin
    next_st = st;
    if (inbandSel) begin
      next_st.thousand_meg_select  = inbandSpeed;
      next_st.full = inbandDuplex;
    end else begin
      // Forced mode: gig bit picks 1G, else 100M; no 10M path here
      next_st.thousand_meg_select  = regGig;
      next_st.full = regDuplex;
    end
    if (stopped_clock_speed_force) begin
      next_st.thousand_meg_select = 1'b1;
    end
    if (next_st.thousand_meg_select) begin
      next_st.full = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  assign linkGig  = st.thousand_meg_select;
  assign linkFull = st.full;

endmodule

// ---- verilog/mmc_mode_control.sv ----
`timescale 1ns/1ns
`include "mmc_defs.svh"

module mmc_mode_control (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  // AXI4-Lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // PHY-side in-band status pins
  input  wire logic        inbandDuplexPin,
  input  wire logic        inbandSpeedPin,
  // Datapath requests
  input  wire logic        rxDescLenWriteReq,
  input  wire logic        rxEopReq,
  input  wire logic        rxFifoTrigger,
  input  wire logic        datapathBusy,
  // Mode outputs
  output logic             inbandReceiveEnable,
  output logic             linkGig,
  output logic             linkFullDuplex,
  output logic             rmiiFullDuplex,
  output logic             rmiiRate25m,
  output logic             rxDescLenWriteEn,
  output logic             rxOwnerWrite,
  output logic             rxOwnerValue,
  output logic             pauseFrameReq,
  output logic             idleCommand,
  output logic             idleReached
);

  typedef struct packed {
    logic [31:0]          ctrl;
    mmc_pkg::mmc_bus_type wrSt;
    mmc_pkg::mmc_bus_type rdSt;
    logic                 awHeld;
    logic [11:0]          awAddr;
    logic                 wHeld;
    logic [31:0]          wData;
    logic [3:0]           wStrb;
    logic [1:0]           bresp;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    logic [1:0]           dupSync;
    logic [1:0]           spdSync;
    mmc_pkg::mmc_idle_type idleSt;
    logic [3:0]           quietCnt;
    logic                 descLenEn;
    logic                 ownWr;
    logic                 ownVal;
    logic                 pause;
    logic                 swEop;
    logic                 swTrig;
  } mmc_state_type;

  mmc_state_type st;
  mmc_state_type next_st;
  logic          gigSel;
  logic          fullSel;
  logic [31:0]   statusWord;

  // Pin inputs pass two flops; only bit 1 is read onward
  mmc_link_select linkSel (
    .mclk         (mclk),
    .rst          (rst),
    .clkEn        (clkEn),
    .inbandSel    (st.ctrl[`MMC_INBAND_SEL_BIT]),
    .inbandDuplex (st.dupSync[1]),
    .inbandSpeed  (st.spdSync[1]),
    .regDuplex    (st.ctrl[`MMC_FULL_DUPLEX_BIT]),
    .regGig       (st.ctrl[`MMC_GIG_BIT]),
    .stopped_clock_speed_force     (st.ctrl[`MMC_GIG_FORCE_BIT]),
    .linkGig      (gigSel),
    .linkFull     (fullSel)
  );

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`MMC_ST_IDLE_BIT]      = (st.idleSt == mmc_pkg::MMC_STOPPED);
    statusWord[`MMC_ST_GIG_BIT]       = gigSel;
    statusWord[`MMC_ST_FULL_BIT]      = fullSel;
    statusWord[`MMC_ST_RMII_RATE_BIT] = st.ctrl[`MMC_RMII_RATE_BIT];
  end

  always_comb begin
    logic [31:0] merged;
    logic        eop;
    logic        trig;
    merged  = st.ctrl;
    eop     = 1'b0;
    trig    = 1'b0;
    next_st = st;
    next_st.swEop  = 1'b0;
    next_st.swTrig = 1'b0;
    next_st.dupSync = {st.dupSync[0], inbandDuplexPin};
    next_st.spdSync = {st.spdSync[0], inbandSpeedPin};

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.wHeld = 1'b1;
      next_st.wData = s_axi_wdata;
      next_st.wStrb = s_axi_wstrb;
    end
    case (st.wrSt)
      mmc_pkg::MMC_BUS_IDLE: begin
        if (st.awHeld && st.wHeld) begin
          next_st.awHeld = 1'b0;
          next_st.wHeld  = 1'b0;
          next_st.wrSt   = mmc_pkg::MMC_BUS_RESP;
          next_st.bresp  = `MMC_RESP_OKAY;
          if (st.awAddr == `MMC_CONTROL_ADDR) begin
            for (int i = 0; i < 4; i++) begin
              if (st.wStrb[i]) begin
                merged[i*8 +: 8] = st.wData[i*8 +: 8];
              end
            end
            // Reserved bits never take a written one
            next_st.ctrl = merged & `MMC_CONTROL_MASK;
          end else if (st.awAddr == `MMC_EVENT_ADDR) begin
            next_st.swEop  = st.wStrb[0] & st.wData[`MMC_EV_EOP_BIT];
            next_st.swTrig = st.wStrb[0] & st.wData[`MMC_EV_FIFO_TRIG_BIT];
          end else if (st.awAddr != `MMC_STATUS_ADDR) begin
            next_st.bresp = `MMC_RESP_SLVERR;
          end
        end
      end
      mmc_pkg::MMC_BUS_RESP: begin
        if (s_axi_bready) begin
          next_st.wrSt = mmc_pkg::MMC_BUS_IDLE;
        end
      end
      default: begin
        next_st.wrSt = mmc_pkg::MMC_BUS_IDLE;
      end
    endcase

    // Read channel
    case (st.rdSt)
      mmc_pkg::MMC_BUS_IDLE: begin
        if (s_axi_arvalid) begin
          next_st.rdSt  = mmc_pkg::MMC_BUS_RESP;
          next_st.rresp = `MMC_RESP_OKAY;
          next_st.rdata = 32'h0000_0000;
          if (s_axi_araddr == `MMC_CONTROL_ADDR) begin
            next_st.rdata = st.ctrl;
          end else if (s_axi_araddr == `MMC_STATUS_ADDR) begin
            next_st.rdata = statusWord;
          end else if (s_axi_araddr != `MMC_EVENT_ADDR) begin
            next_st.rresp = `MMC_RESP_SLVERR;
          end
        end
      end
      mmc_pkg::MMC_BUS_RESP: begin
        if (s_axi_rready) begin
          next_st.rdSt = mmc_pkg::MMC_BUS_IDLE;
        end
      end
      default: begin
        next_st.rdSt = mmc_pkg::MMC_BUS_IDLE;
      end
    endcase

    // Descriptor write-back controls
    eop  = rxEopReq | st.swEop;
    trig = rxFifoTrigger | st.swTrig;
    next_st.descLenEn = rxDescLenWriteReq & ~st.ctrl[`MMC_LEN_BLOCK_BIT];
    next_st.ownWr     = eop;
    if (eop) begin
      next_st.ownVal = st.ctrl[`MMC_OWNER_VAL_BIT];
    end
    // Pause frames only in full duplex and only when enabled
    next_st.pause = trig & st.ctrl[`MMC_RXFIFO_PAUSE_BIT] & fullSel;

    // Idle: wait for the datapath to go quiet before reporting idle
    case (st.idleSt)
      mmc_pkg::MMC_RUN: begin
        next_st.quietCnt = 4'h0;
        if (st.ctrl[`MMC_IDLE_REQ_BIT]) begin
          next_st.idleSt = mmc_pkg::MMC_DRAIN;
        end
      end
      mmc_pkg::MMC_DRAIN: begin
        if (!st.ctrl[`MMC_IDLE_REQ_BIT]) begin
          next_st.idleSt = mmc_pkg::MMC_RUN;
        end else if (datapathBusy) begin
          next_st.quietCnt = 4'h0;
        end else if (st.quietCnt == `MMC_IDLE_QUIET_CYC - 4'h1) begin
          next_st.idleSt = mmc_pkg::MMC_STOPPED;
        end else begin
          next_st.quietCnt = st.quietCnt + 4'h1;
        end
      end
      mmc_pkg::MMC_STOPPED: begin
        if (!st.ctrl[`MMC_IDLE_REQ_BIT]) begin
          next_st.idleSt = mmc_pkg::MMC_RUN;
        end
      end
      default: begin
        next_st.idleSt = mmc_pkg::MMC_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  // Each channel is accepted only while nothing of its kind is pending
  assign s_axi_awready = ~st.awHeld & (st.wrSt == mmc_pkg::MMC_BUS_IDLE);
  assign s_axi_wready  = ~st.wHeld & (st.wrSt == mmc_pkg::MMC_BUS_IDLE);
  assign s_axi_bvalid  = (st.wrSt == mmc_pkg::MMC_BUS_RESP);
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = (st.rdSt == mmc_pkg::MMC_BUS_IDLE);
  assign s_axi_rvalid  = (st.rdSt == mmc_pkg::MMC_BUS_RESP);
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;

  assign inbandReceiveEnable = st.ctrl[`MMC_INBAND_SEL_BIT];
  assign linkGig             = gigSel;
  assign linkFullDuplex      = fullSel;
  // Half duplex is not built; the bit is only passed on
  assign rmiiFullDuplex      = st.ctrl[`MMC_RMII_DUPLEX_BIT];
  assign rmiiRate25m         = st.ctrl[`MMC_RMII_RATE_BIT];
  assign rxDescLenWriteEn    = st.descLenEn;
  assign rxOwnerWrite        = st.ownWr;
  assign rxOwnerValue        = st.ownVal;
  assign pauseFrameReq       = st.pause;
  assign idleCommand         = st.ctrl[`MMC_IDLE_REQ_BIT];
  assign idleReached         = (st.idleSt == mmc_pkg::MMC_STOPPED);

endmodule

// ---- verilog/mmc_pkg.sv ----
package mmc_pkg;

  typedef enum logic [1:0] {
    MMC_BUS_IDLE = 2'h0,
    MMC_BUS_RESP = 2'h1
  } mmc_bus_type;

  typedef enum logic [1:0] {
    MMC_RUN      = 2'h0,
    MMC_DRAIN    = 2'h1,
    MMC_STOPPED  = 2'h3
  } mmc_idle_type;

endpackage
